// ==== inc/nfp_pkg.sv ====
`default_nettype none

package nfp_pkg;

  // Cycle kinds accepted on the request port.
  typedef enum logic [1:0] {
    NFP_OP_CMD  = 2'h0,
    NFP_OP_ADDR = 2'h1,
    NFP_OP_WR   = 2'h2,
    NFP_OP_RD   = 2'h3
  } nfp_op_t;

  // Strobe sequencer states.
  typedef enum logic [1:0] {
    NFP_ST_IDLE  = 2'h0,
    NFP_ST_SETUP = 2'h1,
    NFP_ST_PULSE = 2'h2,
    NFP_ST_HOLD  = 2'h3
  } nfp_state_t;

  // Strobe timing at 100 MHz.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SETUP_NS      = 10;
  localparam int unsigned PULSE_NS      = 30;
  localparam int unsigned HOLD_NS       = 10;
  localparam logic [3:0]  SETUP_CYC     = 4'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  PULSE_CYC     = 4'((PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  HOLD_CYC      = 4'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam int unsigned DATA_W        = 8;
  localparam int unsigned NUM_CE        = 4;
  localparam logic [3:0]  CE_IDLE       = 4'hF;
  localparam logic [7:0]  DATA_RST      = 8'h00;

endpackage : nfp_pkg

`default_nettype wire

// ==== inc/nfp_buf_if.sv ====
`default_nettype none

// Read-data handshake between sequencer and its output buffer.
interface nfp_buf_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : nfp_buf_if

`default_nettype wire

// ==== design/nfp_skid_buf.sv ====
`default_nettype none

// Two-entry buffer: input ready stays high until both entries are taken.
module nfp_skid_buf (
  input  wire logic       ref_clk_i,  // System clock.
  input  wire logic       arst_n_i,   // Asynchronous reset, active low.
  nfp_buf_if.snk          in_if,      // Filling side.
  output logic            valid_o,    // Head entry valid.
  output logic [7:0]      data_o,     // Head entry data.
  input  wire logic       ready_i     // Drain side ready.
);

  logic [7:0] mem_q [2];
  logic [7:0] mem_d [2];
  logic [1:0] cnt_q, cnt_d;
  logic       rd_q, rd_d;
  logic       wr_q, wr_d;
  logic       vld_q, vld_d;
  logic [7:0] head_q, head_d;

  // Pointer, count and storage update.
  always_comb begin
    logic push;
    logic pop;
    push  = in_if.valid && (cnt_q != 2'h2);
    pop   = ready_i && (cnt_q != 2'h0);
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_if.data;
      wr_d        = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
    // Head entry is registered so the drain side sees flip-flop outputs.
    vld_d  = (cnt_d != 2'h0);
    head_d = mem_d[rd_d];
  end

  // Registers.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_q[0] <= nfp_pkg::DATA_RST;
      mem_q[1] <= nfp_pkg::DATA_RST;
      cnt_q    <= 2'h0;
      rd_q     <= 1'b0;
      wr_q     <= 1'b0;
      vld_q    <= 1'b0;
      head_q   <= nfp_pkg::DATA_RST;
    end else begin
      mem_q  <= mem_d;
      cnt_q  <= cnt_d;
      rd_q   <= rd_d;
      wr_q   <= wr_d;
      vld_q  <= vld_d;
      head_q <= head_d;
    end
  end

  // Back-pressure reaches the sequencer.
  assign in_if.ready = (cnt_q != 2'h2);
  assign valid_o     = vld_q;
  assign data_o      = head_q;

endmodule : nfp_skid_buf

`default_nettype wire

// ==== design/nfp_pin_seq.sv ====
`default_nettype none

// Nand pin sequencer: one request becomes one strobed bus cycle.
module nfp_pin_seq (
  input  wire logic        ref_clk_i,            // System clock, 100 MHz.
  input  wire logic        arst_n_i,             // Asynchronous reset, active low.
  input  wire logic        req_valid_i,          // Cycle request.
  output logic             req_ready_o,          // Request accepted this cycle.
  input  wire logic [1:0]  req_op_i,             // Cycle kind, nfp_op_t.
  input  wire logic [7:0]  req_data_i,           // Command, address or write byte.
  input  wire logic [1:0]  req_dev_i,            // Target device 0..3.
  input  wire logic        card_mode_i,          // Shared pins serve card.
  output logic             rd_valid_o,           // Read byte available.
  output logic [7:0]       rd_data_o,            // Read byte.
  input  wire logic        rd_ready_i,           // Reader takes byte.
  input  wire logic [7:0]  mem_data_bus_i,       // Data bus input.
  output logic [7:0]       mem_data_bus_o,       // Data bus output.
  output logic             mem_data_bus_oe_o,    // Data bus driven.
  output logic             addr_latch_strobe_o,  // Address latch strobe.
  output logic             cmd_latch_strobe_o,   // Command latch strobe.
  output logic             mem_read_strobe_n_o,  // Read strobe, active low.
  output logic             mem_write_strobe_n_o, // Write strobe, active low.
  output logic             chip_enable0_n_o,     // Device 0 enable.
  output logic             chip_enable1_n_o,     // Device 1 enable.
  output logic             chip_enable2_n_o,     // Device 2 enable.
  output logic             chip_enable3_n_o,     // Device 3 or card enable.
  input  wire logic        card_write_lock_n_i,  // Card lock, low protects.
  input  wire logic        card_present_n_i,     // Card presence, low present.
  output logic             mem_write_protect_n_o, // Write protect, active low.
  output logic             card_locked_o,        // Card is write protected.
  output logic             card_inserted_o       // Card sits in slot.
);

  nfp_pkg::nfp_state_t st_q, st_d;
  nfp_pkg::nfp_op_t    op_q, op_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] dout_q, dout_d;
  logic       oe_q, oe_d;
  logic       ale_q, ale_d;
  logic       cle_q, cle_d;
  logic       re_n_q, re_n_d;
  logic       we_n_q, we_n_d;
  logic [3:0] ce_n_q, ce_n_d;
  logic       wp_n_q, wp_n_d;
  logic       lock_q, lock_d;
  logic       ins_q, ins_d;
  logic       rdy_q, rdy_d;
  logic       push;
  logic       stall;
  logic [3:0] ce_sel;

  nfp_buf_if rd_if ();

  // One-hot low enable for the requested device; never two at once.
  generate
    for (genvar g = 0; g < nfp_pkg::NUM_CE; g++) begin : g_ce
      assign ce_sel[g] = ~(req_dev_i == 2'(g));
    end
  endgenerate

  assign stall = (op_q == nfp_pkg::NFP_OP_RD) && !rd_if.ready;

  // Sequencer: setup, strobe pulse, hold, then release.
  always_comb begin
    st_d   = st_q;
    op_d   = op_q;
    cnt_d  = cnt_q;
    dout_d = dout_q;
    oe_d   = oe_q;
    ale_d  = ale_q;
    cle_d  = cle_q;
    re_n_d = re_n_q;
    we_n_d = we_n_q;
    ce_n_d = ce_n_q;
    push   = 1'b0;
    rdy_d  = 1'b0;
    case (st_q)
      nfp_pkg::NFP_ST_IDLE: begin
        if (req_valid_i && !rdy_q) begin
          rdy_d  = 1'b1;
          op_d   = nfp_pkg::nfp_op_t'(req_op_i);
          dout_d = req_data_i;
          ce_n_d = ce_sel;
          ale_d  = (nfp_pkg::nfp_op_t'(req_op_i) == nfp_pkg::NFP_OP_ADDR);
          cle_d  = (nfp_pkg::nfp_op_t'(req_op_i) == nfp_pkg::NFP_OP_CMD);
          oe_d   = (nfp_pkg::nfp_op_t'(req_op_i) != nfp_pkg::NFP_OP_RD);
          cnt_d  = nfp_pkg::SETUP_CYC;
          st_d   = nfp_pkg::NFP_ST_SETUP;
        end
      end
      nfp_pkg::NFP_ST_SETUP: begin
        if (cnt_q > 4'h1) begin
          cnt_d = cnt_q - 4'h1;
        end else if (!stall) begin
          re_n_d = (op_q != nfp_pkg::NFP_OP_RD);
          we_n_d = (op_q == nfp_pkg::NFP_OP_RD);
          cnt_d  = nfp_pkg::PULSE_CYC;
          st_d   = nfp_pkg::NFP_ST_PULSE;
        end
      end
      nfp_pkg::NFP_ST_PULSE: begin
        if (cnt_q > 4'h1) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          push   = (op_q == nfp_pkg::NFP_OP_RD);
          re_n_d = 1'b1;
          we_n_d = 1'b1;
          cnt_d  = nfp_pkg::HOLD_CYC;
          st_d   = nfp_pkg::NFP_ST_HOLD;
        end
      end
      nfp_pkg::NFP_ST_HOLD: begin
        if (cnt_q > 4'h1) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          oe_d   = 1'b0;
          ale_d  = 1'b0;
          cle_d  = 1'b0;
          ce_n_d = nfp_pkg::CE_IDLE;
          st_d   = nfp_pkg::NFP_ST_IDLE;
        end
      end
      default: begin
        st_d = nfp_pkg::NFP_ST_IDLE;
      end
    endcase
    // Shared pins: enables 1 and 2 stay off while they sense the card.
    if (card_mode_i) begin
      ce_n_d[1] = 1'b1;
      ce_n_d[2] = 1'b1;
    end
    wp_n_d = 1'b1;
    lock_d = card_mode_i && !card_write_lock_n_i;
    ins_d  = card_mode_i && !card_present_n_i;
  end

  // Registers; write protect sits low through reset.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q   <= nfp_pkg::NFP_ST_IDLE;
      op_q   <= nfp_pkg::NFP_OP_CMD;
      cnt_q  <= 4'h0;
      dout_q <= nfp_pkg::DATA_RST;
      oe_q   <= 1'b0;
      ale_q  <= 1'b0;
      cle_q  <= 1'b0;
      re_n_q <= 1'b1;
      we_n_q <= 1'b1;
      ce_n_q <= nfp_pkg::CE_IDLE;
      wp_n_q <= 1'b0;
      lock_q <= 1'b0;
      ins_q  <= 1'b0;
      rdy_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      op_q   <= op_d;
      cnt_q  <= cnt_d;
      dout_q <= dout_d;
      oe_q   <= oe_d;
      ale_q  <= ale_d;
      cle_q  <= cle_d;
      re_n_q <= re_n_d;
      we_n_q <= we_n_d;
      ce_n_q <= ce_n_d;
      wp_n_q <= wp_n_d;
      lock_q <= lock_d;
      ins_q  <= ins_d;
      rdy_q  <= rdy_d;
    end
  end

  // Read byte sampled at end of strobe pulse.
  assign rd_if.valid = push;
  assign rd_if.data  = mem_data_bus_i;

  nfp_skid_buf u_buf (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .in_if     (rd_if),
    .valid_o   (rd_valid_o),
    .data_o    (rd_data_o),
    .ready_i   (rd_ready_i)
  );

  // Pin outputs straight from flip-flops.
  assign req_ready_o           = rdy_q;
  assign mem_data_bus_o        = dout_q;
  assign mem_data_bus_oe_o     = oe_q;
  assign addr_latch_strobe_o   = ale_q;
  assign cmd_latch_strobe_o    = cle_q;
  assign mem_read_strobe_n_o   = re_n_q;
  assign mem_write_strobe_n_o  = we_n_q;
  assign chip_enable0_n_o      = ce_n_q[0];
  assign chip_enable1_n_o      = ce_n_q[1];
  assign chip_enable2_n_o      = ce_n_q[2];
  assign chip_enable3_n_o      = ce_n_q[3];
  assign mem_write_protect_n_o = wp_n_q;
  assign card_locked_o         = lock_q;
  assign card_inserted_o       = ins_q;

endmodule : nfp_pin_seq

`default_nettype wire

// ==== sim/nfp_sva.sv ====
`default_nettype none

// Pin timing checks of the nand pin sequencer, seen only at its ports.
module nfp_sva (
  input wire logic       ref_clk_i,             // Clock.
  input wire logic       arst_n_i,              // Reset, active low.
  input wire logic       req_ready_o,           // Request taken.
  input wire logic [1:0] req_dev_i,             // Target device.
  input wire logic       card_mode_i,           // Card mode.
  input wire logic       mem_data_bus_oe_o,     // Bus driven.
  input wire logic       addr_latch_strobe_o,   // Address strobe.
  input wire logic       cmd_latch_strobe_o,    // Command strobe.
  input wire logic       mem_read_strobe_n_o,   // Read strobe.
  input wire logic       mem_write_strobe_n_o,  // Write strobe.
  input wire logic       chip_enable0_n_o,      // Enable 0.
  input wire logic       chip_enable1_n_o,      // Enable 1.
  input wire logic       chip_enable2_n_o,      // Enable 2.
  input wire logic       chip_enable3_n_o,      // Enable 3.
  input wire logic       card_write_lock_n_i,   // Card lock.
  input wire logic       mem_write_protect_n_o, // Write protect.
  input wire logic       card_locked_o          // Lock flag.
);
  timeunit 1ns;
  timeprecision 1ps;

  wire logic [3:0] ce_n;

  // All enables as one vector.
  assign ce_n = {chip_enable3_n_o, chip_enable2_n_o, chip_enable1_n_o, chip_enable0_n_o};

  // Every check runs on the rising edge and rests during reset.
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_one_enable: assert property ($countones(~ce_n) <= 1)
    else $error("more than one enable low");
  a_latch_drive: assert property (addr_latch_strobe_o || cmd_latch_strobe_o |->
    mem_data_bus_oe_o && !(addr_latch_strobe_o && cmd_latch_strobe_o))
    else $error("latch strobe without bus drive");
  a_read_release: assert property (!mem_read_strobe_n_o |->
    !mem_data_bus_oe_o && mem_write_strobe_n_o) else $error("bus driven in read");
  a_write_pulse: assert property ($fell(mem_write_strobe_n_o) |->
    !mem_write_strobe_n_o [*3] ##1 mem_write_strobe_n_o) else $error("write pulse length");
  a_read_pulse: assert property ($fell(mem_read_strobe_n_o) |->
    !mem_read_strobe_n_o [*3] ##1 mem_read_strobe_n_o) else $error("read pulse length");
  a_card_gate: assert property (card_mode_i |-> chip_enable1_n_o && chip_enable2_n_o)
    else $error("shared enable driven in card mode");
  a_lock_flag: assert property (card_mode_i && !card_write_lock_n_i ##1 card_mode_i |->
    card_locked_o) else $error("lock flag missing");
  a_wp_after: assert property ($past(arst_n_i) |-> mem_write_protect_n_o)
    else $error("write protect low after reset");
  a_ready_enable: assert property (req_ready_o && !card_mode_i |->
    ce_n == ~(4'h1 << req_dev_i)) else $error("wrong enable for device");

  c_write: cover property ($fell(mem_write_strobe_n_o));
  c_read: cover property ($fell(mem_read_strobe_n_o));
  c_lock: cover property (card_locked_o);
endmodule : nfp_sva

bind nfp_pin_seq nfp_sva i_sva (.*);

`default_nettype wire

// ==== sim/nfp_flash_model.sv ====
`default_nettype none

// Behavioural nand device: latches bytes, returns a counting read byte.
module nfp_flash_model (
  input  wire logic [7:0] bus_o_i,  // Controller bus output.
  input  wire logic       oe_i,     // Controller drives bus.
  input  wire logic       ale_i,    // Address strobe.
  input  wire logic       cle_i,    // Command strobe.
  input  wire logic       re_n_i,   // Read strobe.
  input  wire logic       we_n_i,   // Write strobe.
  input  wire logic [3:0] ce_n_i,   // Enables.
  output logic      [7:0] bus_i_o,  // Resolved bus level.
  output logic      [7:0] cmd_o,    // Last command.
  output logic      [7:0] addr_o,   // Last address.
  output logic      [3:0] ce_o      // Enables at last write.
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem_q = 8'h00;
  logic       we_l  = 1'b1;
  logic       re_l  = 1'b1;

  // Released bus shows the stored byte while the read strobe is low, else its inverse, not a stale value.
  assign bus_i_o = oe_i ? bus_o_i : (!re_n_i ? mem_q : ~mem_q);

  // One process owns the stored byte: a rising write strobe latches by kind,
  // a rising read strobe moves on to the next byte. The start-up level of the
  // strobes is not taken as an edge.
  always @(we_n_i or re_n_i) begin
    if (we_n_i === 1'b1 && we_l === 1'b0) begin
      ce_o <= ce_n_i;
      if (cle_i) begin
        cmd_o <= bus_o_i;
      end else if (ale_i) begin
        addr_o <= bus_o_i;
      end else begin
        mem_q <= bus_o_i;
      end
    end
    if (re_n_i === 1'b1 && re_l === 1'b0) begin
      mem_q <= mem_q + 8'h01;
    end
    we_l = we_n_i;
    re_l = re_n_i;
  end
endmodule : nfp_flash_model

`default_nettype wire

// ==== sim/nand_flash_pin_interface_tb.sv ====
`default_nettype none

module nand_flash_pin_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 0, arst_n_i = 0, req_valid_i = 0, card_mode_i = 0, rd_ready_i = 0;
  logic [1:0] req_op_i = 0, req_dev_i = 0;
  logic [7:0] req_data_i = 0, mem_data_bus_i, mem_data_bus_o, rd_data_o, m_cmd, m_addr;
  logic req_ready_o, rd_valid_o, mem_data_bus_oe_o, addr_latch_strobe_o, cmd_latch_strobe_o;
  logic mem_read_strobe_n_o, mem_write_strobe_n_o, mem_write_protect_n_o;
  logic chip_enable0_n_o, chip_enable1_n_o, chip_enable2_n_o, chip_enable3_n_o;
  logic card_write_lock_n_i = 1, card_present_n_i = 1, card_locked_o, card_inserted_o;
  logic [3:0] m_ce;
  int error_cnt = 0, check_count = 0;

  nfp_pin_seq i_dut (.*);
  nfp_flash_model i_mem (.bus_o_i(mem_data_bus_o), .oe_i(mem_data_bus_oe_o),
    .ale_i(addr_latch_strobe_o), .cle_i(cmd_latch_strobe_o), .re_n_i(mem_read_strobe_n_o),
    .we_n_i(mem_write_strobe_n_o), .ce_n_i({chip_enable3_n_o, chip_enable2_n_o,
    chip_enable1_n_o, chip_enable0_n_o}), .bus_i_o(mem_data_bus_i), .cmd_o(m_cmd),
    .addr_o(m_addr), .ce_o(m_ce));

  // Clock of 10 ns period.
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk

  // One request, held until taken, then held one more cycle and followed by five idle cycles.
  task automatic op(logic [1:0] o, logic [7:0] d, logic [1:0] v);
    int i;
    @(negedge ref_clk_i);
    {req_valid_i, req_op_i, req_data_i, req_dev_i} = {1'b1, o, d, v};
    for (i = 0; i < 20 && req_ready_o !== 1'b1; i++) @(negedge ref_clk_i);
    chk("req_ready", 8'h01, {7'h00, req_ready_o});
    @(negedge ref_clk_i);
    req_valid_i = 0;
    repeat (5) @(negedge ref_clk_i);
  endtask : op

  task automatic test_write();
    for (int v = 0; v < 4; v++) begin
      op(2'h0, 8'h80, v[1:0]);
      op(2'h1, 8'h10 + v[7:0], v[1:0]);
      op(2'h2, 8'hC0 + v[7:0], v[1:0]);
      chk("cmd", 8'h80, m_cmd);
      chk("addr", 8'h10 + v[7:0], m_addr);
      chk("enables", {4'h0, ~(4'h1 << v)}, {4'h0, m_ce});
    end
    $display("test write done");
  endtask : test_write

  // Three reads with the reader stalled: two fill the buffer, one waits.
  task automatic test_read();
    int i;
    for (int k = 0; k < 3; k++) op(2'h3, 8'h00, 2'h0);
    for (int k = 0; k < 3; k++) begin
      for (i = 0; i < 30 && rd_valid_o !== 1'b1; i++) @(negedge ref_clk_i);
      chk("rd_data", 8'hC3 + k[7:0], rd_data_o);
      rd_ready_i = 1;
      @(negedge ref_clk_i);
      rd_ready_i = 0;
    end
    repeat (8) @(negedge ref_clk_i);
    chk("rd_valid", 8'h00, {7'h00, rd_valid_o});
    $display("test read done");
  endtask : test_read

  task automatic test_card();
    card_mode_i = 1;
    {card_write_lock_n_i, card_present_n_i} = 2'b00;
    repeat (3) @(negedge ref_clk_i);
    chk("locked", 8'h01, {7'h00, card_locked_o});
    chk("inserted", 8'h01, {7'h00, card_inserted_o});
    op(2'h2, 8'h5A, 2'h3);
    chk("card enable", 8'h07, {4'h0, m_ce});
    op(2'h2, 8'hA5, 2'h1);
    chk("card gate", 8'h0F, {4'h0, m_ce});
    {card_write_lock_n_i, card_present_n_i} = 2'b11;
    repeat (3) @(negedge ref_clk_i);
    chk("unlocked", 8'h00, {6'h00, card_locked_o, card_inserted_o});
    card_mode_i = 0;
    $display("test card done");
  endtask : test_card

  task automatic test_reset();
    @(negedge ref_clk_i);
    arst_n_i = 0;
    #1 chk("wp in reset", 8'h00, {7'h00, mem_write_protect_n_o});
    chk("pins in reset", 8'h0F, {3'h0, mem_data_bus_oe_o, chip_enable3_n_o, chip_enable2_n_o,
      chip_enable1_n_o, chip_enable0_n_o});
    repeat (6) @(negedge ref_clk_i);
    arst_n_i = 1;
    repeat (2) @(negedge ref_clk_i);
    chk("wp after reset", 8'h01, {7'h00, mem_write_protect_n_o});
    $display("test reset done");
  endtask : test_reset

  // Watchdog far beyond the few hundred cycles the tests need.
  initial begin
    #100us;
    error_cnt++;
    finish_test();
  end

  // Main sequence.
  initial begin
    repeat (6) @(negedge ref_clk_i);
    arst_n_i = 1;
    repeat (2) @(negedge ref_clk_i);
    test_write();
    test_read();
    test_card();
    test_reset();
    finish_test();
  end
endmodule : nand_flash_pin_interface_tb

`default_nettype wire
